// File: design/rbb_pkg.sv
// package of constants and carrier types for the byte bus port
package rbb_pkg;
  // register address and data widths
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  // number of implemented register locations
  localparam int unsigned NUM_REGS = 17;
  // location index of the update control register
  localparam logic [4:0] ADDR_CTRL = 5'h0F;
  // location index of the power control register
  localparam logic [4:0] ADDR_PWR = 5'h10;
  // bit of the control register that enables user copy transfers
  localparam int unsigned TE_BIT = 7;
  // bit of the power control register that holds the power-on request
  localparam int unsigned PWR_BIT = 0;
  // reset value of the transfer enable bit
  localparam logic CTRL_TE_RST = 1'b1;
  // number of timekeeping locations; only the seconds location is double buffered
  localparam int unsigned NUM_TK = 8;
  // recovery time after power returns, in ns
  localparam int unsigned REC_NS = 150000;
  // clock period in ns
  localparam int unsigned CLK_NS = 10;
  // recovery count in cycles, least time rounded up
  localparam int unsigned REC_CYC = (REC_NS + CLK_NS - 1) / CLK_NS;
  // counter width for the recovery count
  localparam int unsigned REC_W = 20;
  // idle value of an all-zero byte
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // host strobes and address as seen by the port
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [4:0] reg_addr;
  } rbb_bus_t;

  // event inputs that may raise the control outputs
  typedef struct packed {
    logic tod_alarm;
    logic wd_timeout;
    logic kick;
  } rbb_evt_t;

  // port access mode
  typedef enum logic [2:0] {
    MODE_DESEL = 3'b001,
    MODE_READ = 3'b010,
    MODE_WRITE = 3'b100
  } rbb_mode_t;
endpackage : rbb_pkg

// File: design/rbb_regmem.sv
// small register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module rbb_regmem (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // read port
  input wire logic [4:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  // storage for the implemented locations
  logic [7:0] mem_q [rbb_pkg::NUM_REGS];
  // address range checks
  wire wr_ok = wr_addr_i < 5'(rbb_pkg::NUM_REGS);
  wire rd_ok = rd_addr_i < 5'(rbb_pkg::NUM_REGS);

  // write path, unmapped locations ignored
  always_ff @(posedge clock_i) begin
    if (wr_en_i && wr_ok) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read, unmapped locations read zero
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= rbb_pkg::BYTE_ZERO;
    end else if (rd_ok) begin
      rd_data_o <= mem_q[rd_addr_i];
    end else begin
      rd_data_o <= rbb_pkg::BYTE_ZERO;
    end
  end
endmodule : rbb_regmem
`default_nettype wire

// File: design/rbb_port.sv
// byte-wide host port of the clock/calendar with power-fail gating
`timescale 1ns/100ps
`default_nettype none
module rbb_port (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // host bus strobes and address
  input wire rbb_pkg::rbb_bus_t bus_i,
  // data bus pins
  input wire logic [7:0] data_bus_i,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe_o,
  // external memory enable
  input wire logic sram_enable_in_n_i,
  output logic sram_enable_out_n_o,
  // power and event inputs
  input wire logic power_fail_trip_i,
  input wire logic kickstart_in_n_i,
  input wire rbb_pkg::rbb_evt_t evt_i,
  // event routing selections
  input wire logic evt_to_irq_i,
  input wire logic evt_to_rst_i,
  // timekeeping tick from the timebase
  input wire logic tick_i,
  // control outputs, open drain, enable high means pull low
  output logic irq_oe_o,
  output logic rst_oe_o,
  output logic power_on_out_n_oe_o,
  // user copy of the seconds location for inspection
  output logic [7:0] time_user_o
);
  // synchronised reset chain
  logic rst_s1_q;
  logic rst_s2_q;
  // reset release through two flops
  // assertion reaches every flop with a reset at once, release waits two edges
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // power fail synchroniser, first flop read only by the second
  logic pf_s1_q;
  logic pf_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pf_s1_q <= 1'b1;
      pf_q <= 1'b1;
    end else begin
      pf_s1_q <= power_fail_trip_i;
      pf_q <= pf_s1_q;
    end
  end

  // recovery counter for the reset output
  logic [rbb_pkg::REC_W-1:0] rec_q;
  logic [rbb_pkg::REC_W-1:0] rec_d;
  wire rec_done = (rec_q == rbb_pkg::REC_W'(rbb_pkg::REC_CYC));
  assign rec_d = pf_q ? '0 : (rec_done ? rec_q : rec_q + 1'b1);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rec_q <= '0;
    end else begin
      rec_q <= rec_d;
    end
  end

  // reset output held while failed or recovering
  // the event reset below joins it, and both refuse the host
  wire por_active = pf_q || !rec_done;

  // event-driven reset request, cleared while the power-on reset holds
  logic evt_rst_q;
  wire any_evt = evt_i.tod_alarm || evt_i.wd_timeout || evt_i.kick;
  wire reset_out = por_active || evt_rst_q;
  wire access_ok = !pf_q && !reset_out;

  // strobe decode
  // deselect unless chip select low
  wire sel = access_ok && !bus_i.cs_n;
  wire wr_act = sel && !bus_i.we_n;
  wire rd_act = sel && !bus_i.oe_n && bus_i.we_n;
  wire addr_ok = bus_i.reg_addr < 5'(rbb_pkg::NUM_REGS);
  // one-hot mode word, write takes priority over read
  wire rbb_pkg::rbb_mode_t mode = wr_act ? rbb_pkg::MODE_WRITE :
    (rd_act ? rbb_pkg::MODE_READ : rbb_pkg::MODE_DESEL);

  // write cycle tracking
  // data is re-latched on every write edge, so the last sampled byte wins
  logic wr_act_q;
  logic [4:0] wr_addr_q;
  logic [7:0] wr_data_q;
  // data committed at end of cycle
  wire wr_end = wr_act_q && !wr_act;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= rbb_pkg::BYTE_ZERO;
    end else begin
      wr_act_q <= wr_act;
      // latch address and host data during cycle
      if (wr_act) begin
        wr_addr_q <= bus_i.reg_addr;
        wr_data_q <= data_bus_i;
      end
    end
  end

  // write commits into storage at cycle end
  // a write cut short by power fail or reset is dropped
  wire commit = wr_end && access_ok;
  wire commit_ctrl = commit && (wr_addr_q == rbb_pkg::ADDR_CTRL);
  wire commit_pwr = commit && (wr_addr_q == rbb_pkg::ADDR_PWR);

  // transfer enable flag
  logic te_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      te_q <= rbb_pkg::CTRL_TE_RST;
    end else if (commit_ctrl) begin
      te_q <= wr_data_q[rbb_pkg::TE_BIT];
    end
  end

  // internal and user copies of seconds counter
  logic [7:0] time_int_q;
  logic [7:0] time_user_q;
  // a host write lands in both copies, so a later transfer keeps it
  wire user_wr_time = commit && (wr_addr_q == '0);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      time_int_q <= rbb_pkg::BYTE_ZERO;
    end else if (user_wr_time) begin
      time_int_q <= wr_data_q;
    end else if (tick_i) begin
      time_int_q <= time_int_q + 8'h01;
    end
  end
  // user copy loads from the internal copy only while enabled
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      time_user_q <= rbb_pkg::BYTE_ZERO;
    end else if (user_wr_time) begin
      time_user_q <= wr_data_q;
    end else if (te_q) begin
      time_user_q <= time_int_q;
    end
  end
  assign time_user_o = time_user_q;

  // power-on request latch
  logic pwr_on_q;
  wire pwr_set = !kickstart_in_n_i || evt_i.tod_alarm;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_on_q <= 1'b0;
    end else if (pwr_set) begin
      pwr_on_q <= 1'b1;
    end else if (commit_pwr && !wr_data_q[rbb_pkg::PWR_BIT]) begin
      pwr_on_q <= 1'b0;
    end
  end

  // event reset latch, cleared only while the power-on reset holds
  // set wins, so an event in the same cycle is not lost
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      evt_rst_q <= 1'b0;
    end else if (any_evt && evt_to_rst_i) begin
      evt_rst_q <= 1'b1;
    end else if (por_active) begin
      evt_rst_q <= 1'b0;
    end
  end

  // interrupt latch, cleared by write to control register
  // set wins over a same-cycle clear so no event is lost
  logic irq_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (any_evt && evt_to_irq_i) begin
      irq_q <= 1'b1;
    end else if (commit_ctrl) begin
      irq_q <= 1'b0;
    end
  end

  // register memory holds the general locations
  logic [7:0] mem_rd;
  rbb_regmem u_mem (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .wr_en_i(commit),
    .wr_addr_i(wr_addr_q),
    .wr_data_i(wr_data_q),
    .rd_addr_i(bus_i.reg_addr),
    .rd_data_o(mem_rd)
  );

  // read data selection, live copies over stored bytes
  // the registered address keeps the selection in step with memory data
  logic [4:0] rd_addr_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_q <= '0;
    end else begin
      rd_addr_q <= bus_i.reg_addr;
    end
  end
  wire [7:0] ctrl_rd = {te_q, 7'h00};
  wire [7:0] pwr_rd = {7'h00, pwr_on_q};
  wire [7:0] rd_mux = (rd_addr_q == '0) ? time_user_q :
    (rd_addr_q == rbb_pkg::ADDR_CTRL) ? ctrl_rd :
    (rd_addr_q == rbb_pkg::ADDR_PWR) ? pwr_rd : mem_rd;
  // address change marks data indeterminate for a cycle, shown as zero
  wire addr_stable = (rd_addr_q == bus_i.reg_addr);

  // write enable low stops the drive
  wire oe_d = (mode == rbb_pkg::MODE_READ) && addr_ok;
  // the zero stands for the indeterminate window after an address move
  wire [7:0] dout_d = addr_stable ? rd_mux : rbb_pkg::BYTE_ZERO;

  // registered data pins, released while not reading
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      data_bus_o <= rbb_pkg::BYTE_ZERO;
      data_bus_oe_o <= 1'b0;
    end else begin
      data_bus_o <= dout_d;
      data_bus_oe_o <= oe_d;
    end
  end

  // external memory enable, inactive while the synchronised power fail input is high
  // forced high on fail; follows input otherwise
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sram_enable_out_n_o <= 1'b1;
    end else begin
      sram_enable_out_n_o <= pf_q | sram_enable_in_n_i;
    end
  end

  // open-drain control pulls, the reset pull starts asserted
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_oe_o <= 1'b0;
      rst_oe_o <= 1'b1;
      power_on_out_n_oe_o <= 1'b0;
    end else begin
      irq_oe_o <= irq_q;
      rst_oe_o <= reset_out;
      power_on_out_n_oe_o <= pwr_on_q;
    end
  end
endmodule : rbb_port
`default_nettype wire

// File: testbench/rbb_port_asserts.sv
// pin-level checker of the byte bus port
`timescale 1ns/100ps
`default_nettype none
module rbb_port_asserts (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // watched pins
  input wire rbb_pkg::rbb_bus_t bus_i,
  input wire logic data_bus_oe_o,
  input wire logic sram_enable_in_n_i,
  input wire logic sram_enable_out_n_o,
  input wire logic power_fail_trip_i,
  input wire rbb_pkg::rbb_evt_t evt_i,
  input wire logic evt_to_irq_i,
  input wire logic evt_to_rst_i,
  input wire logic irq_oe_o,
  input wire logic rst_oe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [19:0] good_q; // cycles of good supply
  // count good supply cycles, saturating
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) good_q <= 20'h00000;
    else if (power_fail_trip_i) good_q <= 20'h00000;
    else if (~&good_q) good_q <= good_q + 20'h00001;
  end
  AST_DRV: assert property (data_bus_oe_o |->
    !$past(bus_i.cs_n) && !$past(bus_i.oe_n) && $past(bus_i.we_n))
    else $error("drive outside read");
  AST_ADR: assert property (data_bus_oe_o |->
    $past(bus_i.reg_addr) < 5'(rbb_pkg::NUM_REGS)) else $error("drive of unmapped place");
  AST_BLK: assert property (rst_oe_o [*3] |-> !data_bus_oe_o)
    else $error("drive while reset out");
  AST_PFR: assert property (power_fail_trip_i [*4] |-> rst_oe_o)
    else $error("no reset out on supply loss");
  AST_REC: assert property ($fell(rst_oe_o) |->
    good_q >= rbb_pkg::REC_CYC && good_q <= rbb_pkg::REC_CYC + 16) else $error("recovery time");
  AST_CEO: assert property (power_fail_trip_i [*4] |-> sram_enable_out_n_o)
    else $error("sram enable not blocked");
  AST_FOL: assert property ((!power_fail_trip_i) [*8] |->
    sram_enable_out_n_o == $past(sram_enable_in_n_i)) else $error("sram enable copy");
  AST_IRQ: assert property (evt_i.tod_alarm && evt_to_irq_i |-> ##[1:4] irq_oe_o)
    else $error("alarm without interrupt");
  AST_WDR: assert property (evt_i.wd_timeout && evt_to_rst_i |-> ##[1:4] rst_oe_o)
    else $error("watchdog without reset");
endmodule : rbb_port_asserts
bind rbb_port rbb_port_asserts u_rbb_port_asserts (.clock_i, .rst_n_i, .bus_i,
  .data_bus_oe_o, .sram_enable_in_n_i, .sram_enable_out_n_o, .power_fail_trip_i,
  .evt_i, .evt_to_irq_i, .evt_to_rst_i, .irq_oe_o, .rst_oe_o);
`default_nettype wire

// File: testbench/rbb_host.sv
// host processor model driving the byte bus
`timescale 1ns/100ps
`default_nettype none
module rbb_host (
  // clock
  input wire logic clock_i,
  // device data pins
  input wire logic [7:0] data_bus_o,
  input wire logic data_bus_oe_o,
  // strobes and resolved data wire
  output var rbb_pkg::rbb_bus_t bus_o,
  output logic [7:0] dq_o
);
  logic [7:0] hd_q; // last host byte
  logic drv_q; // host drives the wire
  assign dq_o = data_bus_oe_o ? data_bus_o : (drv_q ? hd_q : ~hd_q);
  initial begin
    bus_o = 8'hE0;
    hd_q = 8'h00;
    drv_q = 1'b0;
  end
  // raw strobe pattern after an edge
  task automatic put(input logic [7:0] b);
    @(posedge clock_i);
    bus_o <= b;
  endtask : put
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic oe_n);
    put({1'b0, oe_n, 1'b0, a});
    hd_q <= d;
    drv_q <= 1'b1;
    repeat (2) @(posedge clock_i);
    put({3'b111, a});
    drv_q <= 1'b0;
    @(posedge clock_i);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
    put({3'b001, a});
    repeat (3) @(posedge clock_i);
    #1;
    d = dq_o;
    v = data_bus_oe_o;
    put({3'b111, a});
    @(posedge clock_i);
  endtask : rd
endmodule : rbb_host
`default_nettype wire

// File: testbench/rbb_port_test.sv
// self-checking bench of the byte bus port
`timescale 1ns/100ps
`default_nettype none
module rbb_port_test;
  logic clock_i; // system clock
  logic rst_n_i; // reset, active low
  rbb_pkg::rbb_bus_t bus; // host strobes
  rbb_pkg::rbb_evt_t evt; // event inputs
  logic [7:0] dq, dout, tu, rd; // wire, device byte, user seconds, read byte
  logic oe, sin_n, sout_n, pf, ks_n, t_irq, t_rst, tick, irq, rst, power_on_out_n, v;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  rbb_port u_rbb_port (.clock_i, .rst_n_i, .bus_i(bus), .data_bus_i(dq), .data_bus_o(dout),
    .data_bus_oe_o(oe), .sram_enable_in_n_i(sin_n), .sram_enable_out_n_o(sout_n),
    .power_fail_trip_i(pf), .kickstart_in_n_i(ks_n), .evt_i(evt), .evt_to_irq_i(t_irq),
    .evt_to_rst_i(t_rst), .tick_i(tick), .irq_oe_o(irq), .rst_oe_o(rst),
    .power_on_out_n_oe_o(power_on_out_n), .time_user_o(tu));
  rbb_host u_rbb_host (.clock_i, .data_bus_o(dout), .data_bus_oe_o(oe), .bus_o(bus), .dq_o(dq));
  // compare one byte and count it
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // cut a hang short
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock_i);
      tick <= 1'b1;
      @(posedge clock_i);
      tick <= 1'b0;
    end
    repeat (4) @(posedge clock_i);
  endtask : ticks
  // supply returns, reset out must wait
  task automatic recover;
    int n = 0;
    @(posedge clock_i);
    pf <= 1'b0;
    while (rst !== 1'b0 && n < 15100) begin
      @(posedge clock_i);
      n++;
    end
    chk("recovery", 8'h01, 8'(n >= rbb_pkg::REC_CYC && n < 15100));
  endtask : recover
  task automatic t_pwrup;
    repeat (4) @(posedge clock_i);
    chk("reset out", 8'h01, 8'(rst));
    chk("sram out", 8'h01, 8'(sout_n));
    recover();
    sin_n <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk("sram follow", 8'h00, 8'(sout_n));
  endtask : t_pwrup
  task automatic t_te;
    ticks(2);
    chk("user copy", 8'h02, tu);
    u_rbb_host.wr(rbb_pkg::ADDR_CTRL, 8'h00, 1'b1);
    ticks(3);
    chk("frozen copy", 8'h02, tu);
    u_rbb_host.wr(rbb_pkg::ADDR_CTRL, 8'h80, 1'b1);
    repeat (4) @(posedge clock_i);
    chk("resumed copy", 8'h05, tu);
  endtask : t_te
  task automatic t_rw;
    for (int a = 1; a < 15; a++) u_rbb_host.wr(5'(a), 8'(a) ^ 8'hA5, 1'b1);
    for (int a = 1; a < 15; a++) begin
      u_rbb_host.rd(5'(a), rd, v);
      chk("read back", 8'(a) ^ 8'hA5, rd);
    end
    u_rbb_host.rd(5'h11, rd, v);
    chk("unmapped drive", 8'h00, 8'(v));
  endtask : t_rw
  task automatic t_strobes;
    u_rbb_host.put(8'hA1);
    repeat (3) @(posedge clock_i);
    chk("deselect drive", 8'h00, 8'(oe));
    u_rbb_host.put(8'h61);
    repeat (3) @(posedge clock_i);
    chk("idle drive", 8'h00, 8'(oe));
    u_rbb_host.put(8'hC3);
    repeat (3) @(posedge clock_i);
    u_rbb_host.rd(5'h03, rd, v);
    chk("ignored write", 8'h03 ^ 8'hA5, rd);
    u_rbb_host.put(8'h21);
    u_rbb_host.put(8'h22);
    repeat (3) @(posedge clock_i);
    chk("ripple data", 8'h02 ^ 8'hA5, dq);
    u_rbb_host.wr(5'h02, 8'h3C, 1'b0);
    u_rbb_host.rd(5'h02, rd, v);
    chk("write under enable", 8'h3C, rd);
  endtask : t_strobes
  task automatic t_pf;
    @(posedge clock_i);
    pf <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk("sram blocked", 8'h01, 8'(sout_n));
    u_rbb_host.wr(5'h01, 8'h77, 1'b1);
    u_rbb_host.rd(5'h01, rd, v);
    chk("fail drive", 8'h00, 8'(v));
    recover();
    u_rbb_host.rd(5'h01, rd, v);
    chk("dropped write", 8'h01 ^ 8'hA5, rd);
  endtask : t_pf
  task automatic t_events;
    @(posedge clock_i);
    t_irq <= 1'b1;
    evt <= 3'b100;
    @(posedge clock_i);
    evt <= 3'b000;
    repeat (4) @(posedge clock_i);
    chk("irq", 8'h01, 8'(irq));
    chk("alarm power on", 8'h01, 8'(power_on_out_n));
    u_rbb_host.wr(rbb_pkg::ADDR_CTRL, 8'h80, 1'b1);
    u_rbb_host.wr(rbb_pkg::ADDR_PWR, 8'h00, 1'b1);
    repeat (2) @(posedge clock_i);
    chk("irq cleared", 8'h00, 8'(irq));
    chk("power cleared", 8'h00, 8'(power_on_out_n));
    evt <= 3'b001;
    @(posedge clock_i);
    evt <= 3'b000;
    repeat (4) @(posedge clock_i);
    chk("kick irq", 8'h01, 8'(irq));
    ks_n <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk("power on", 8'h01, 8'(power_on_out_n));
    ks_n <= 1'b1;
    u_rbb_host.wr(rbb_pkg::ADDR_PWR, 8'h00, 1'b1);
    repeat (2) @(posedge clock_i);
    chk("power off", 8'h00, 8'(power_on_out_n));
    t_rst <= 1'b1;
    evt <= 3'b010;
    @(posedge clock_i);
    evt <= 3'b000;
    repeat (4) @(posedge clock_i);
    chk("watchdog reset", 8'h01, 8'(rst));
    u_rbb_host.rd(5'h01, rd, v);
    chk("blocked read", 8'h00, 8'(v));
  endtask : t_events
  initial begin
    rst_n_i = 1'b0;
    pf = 1'b1;
    sin_n = 1'b1;
    ks_n = 1'b1;
    evt = 3'b000;
    t_irq = 1'b0;
    t_rst = 1'b0;
    tick = 1'b0;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_pwrup();
    t_te();
    t_rw();
    t_strobes();
    t_pf();
    t_events();
    print_verdict();
  end
endmodule : rbb_port_test
`default_nettype wire
